// ==== hdl/wdt_defs.svh ====
// offsets, key values, reset values and timing counts of the keyed watchdog
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// register word indices; byte address is four times the index
`define WDT_IDX_CTRL      10'h097
`define WDT_IDX_STAT      10'h098

// command key bytes written to the control register
`define WDT_KEY_RESTART   8'ha5
`define WDT_KEY_DIS_FIRST 8'hde
`define WDT_KEY_DIS_LAST  8'had
`define WDT_KEY_LOCK      8'hff

// control register fields
`define WDT_CMD_BIT       7
`define WDT_IV_W          3
`define WDT_IV_RST        3'h7

// counter and prescaler widths
`define WDT_CNT_W         16
`define WDT_DIV_W         5
`define WDT_DIV_LAST      5'h1f

// disable keys must follow within this many core clock cycles
`define WDT_DIS_WINDOW    3'h4

// divided oscillator periods before a command takes effect
`define WDT_RESTART_TICKS 2'h2
`define WDT_DISABLE_TICKS 2'h3

`endif

// ==== hdl/wdt_pkg.sv ====
// types shared by the keyed watchdog modules
package wdt_pkg;

  // command waiting for the slow clock to take effect
  typedef enum logic [1:0] {
    CMD_NONE,
    CMD_RESTART,
    CMD_DISABLE
  } cmd_t;

endpackage : wdt_pkg

// ==== hdl/lfo_edge_sync.sv ====
// three-flop sampler turning the oscillator pin into one-cycle rise pulses
module lfo_edge_sync (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  // raw oscillator pin and its rise pulse
  input  wire logic lfo_i,
  output logic      rise_o
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;
  logic agree;

  // a change counts only once the second and third stages agree
  assign agree = (s2_q == s3_q);

  // s1 feeds s2 only, so metastability stays out of the decision
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
      rise_o  <= 1'b0;
    end else begin
      s1_q    <= lfo_i;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      if (agree) begin
        level_q <= s3_q;
      end
      rise_o  <= agree & s3_q & ~level_q;
    end
  end

endmodule : lfo_edge_sync

// ==== hdl/timeout_cmp.sv ====
// comparator of the watchdog count against the interval limit
`include "wdt_defs.svh"
module timeout_cmp (
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   sys_rst_i,
  // count and interval
  input  wire logic [`WDT_CNT_W-1:0]  cnt_i,
  input  wire logic [`WDT_IV_W-1:0]   iv_i,
  // limit reached
  output logic                        hit_o
);

  // limit of 4^(iv+3) oscillator periods, in prescaled ticks: 2^(2*iv+1)
  function automatic logic [`WDT_CNT_W-1:0] limit_of(input logic [`WDT_IV_W-1:0] iv);
    logic [3:0] sh;
    sh = {iv, 1'b1};
    limit_of = 16'h0001 << sh;
  endfunction : limit_of

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      hit_o <= 1'b0;
    end else begin
      hit_o <= (cnt_i >= limit_of(iv_i));
    end
  end

endmodule : timeout_cmp

// ==== hdl/keyed_watchdog_timer.sv ====
// keyed watchdog timer with a classic wishbone register slave
//
// Added by the designer: register access over Wishbone.
`include "wdt_defs.svh"
module keyed_watchdog_timer (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // oscillator pin and its keep-running request
  input  wire logic        low_freq_oscillator_i,
  output logic             lfo_force_on_o,
  // internal system reset request
  output logic             wdt_rst_req_o
);

  // state: enable, lock, interval, count, prescaler, disable window, command slot
  // every register but lfo_force_on_o has a _d companion so the clocked blocks stay one-liners
  logic                   en_q;
  logic                   en_d;
  logic                   lock_q;
  logic                   lock_d;
  logic [`WDT_IV_W-1:0]   iv_q;
  logic [`WDT_IV_W-1:0]   iv_d;
  logic [`WDT_CNT_W-1:0]  cnt_q;
  logic [`WDT_CNT_W-1:0]  cnt_d;
  logic [`WDT_DIV_W-1:0]  div_q;
  logic [`WDT_DIV_W-1:0]  div_d;
  logic [2:0]             win_q;
  logic [2:0]             win_d;
  wdt_pkg::cmd_t          cmd_q;
  wdt_pkg::cmd_t          cmd_d;
  logic [1:0]             wait_q;
  logic [1:0]             wait_d;
  logic                   rst_req_d;
  logic [31:0]            dat_d;
  logic                   ack_d;

  // oscillator sampling and the divided tick
  // the pin is asynchronous, so only the synchronised rise pulse is used here
  logic lfo_rise;
  logic tick;
  logic hit;

  lfo_edge_sync u_lfo_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .lfo_i     (low_freq_oscillator_i),
    .rise_o    (lfo_rise)
  );

  // divided clock: one tick every 32 oscillator periods
  assign tick = lfo_rise & (div_q == `WDT_DIV_LAST);

  timeout_cmp u_cmp (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .cnt_i     (cnt_q),
    .iv_i      (iv_q),
    .hit_o     (hit)
  );

  // wishbone decode; a write lands at the edge where ack is high
  // taking the write at the ack edge keeps one bus cycle to one command
  logic       bus_req;
  logic       hit_ctrl;
  logic       hit_stat;
  logic       wr_ctrl;
  logic [7:0] wbyte;

  assign bus_req  = wb_cyc_i & wb_stb_i;
  assign hit_ctrl = (wb_adr_i[11:2] == `WDT_IDX_CTRL);
  assign hit_stat = (wb_adr_i[11:2] == `WDT_IDX_STAT);
  assign wr_ctrl  = bus_req & wb_ack_o & wb_we_i & wb_sel_i[0] & hit_ctrl;
  assign wbyte    = wb_dat_i[7:0];

  // answer one cycle after the request, then drop for a cycle
  assign ack_d = bus_req & ~wb_ack_o;

  // key decode
  // keys only count on a taken write with byte lane 0 enabled
  logic is_restart;
  logic is_dis_first;
  logic is_dis_last;
  logic is_lock;
  logic is_iv;
  logic dis_ok;

  assign is_restart   = wr_ctrl & (wbyte == `WDT_KEY_RESTART);
  assign is_dis_first = wr_ctrl & (wbyte == `WDT_KEY_DIS_FIRST);
  assign is_dis_last  = wr_ctrl & (wbyte == `WDT_KEY_DIS_LAST);
  assign is_lock      = wr_ctrl & (wbyte == `WDT_KEY_LOCK);
  // bit 7 low is an interval write
  assign is_iv        = wr_ctrl & ~wbyte[`WDT_CMD_BIT];

  assign dis_ok = is_dis_last & (win_q != 3'h0) & ~lock_q;

  // window opened by the first key; any other control write closes it
  always_comb begin
    win_d = win_q;
    if (is_dis_first) begin
      win_d = `WDT_DIS_WINDOW;
    end else if (wr_ctrl) begin
      win_d = 3'h0;
    end else if (win_q != 3'h0) begin
      win_d = win_q - 3'h1;
    end
  end

  // command slot: one command waits for slow ticks before it applies
  // a second command inside one divided period simply replaces the first
  logic apply;
  logic apply_restart;
  logic apply_disable;

  assign apply         = tick & (wait_q == 2'h1) & (cmd_q != wdt_pkg::CMD_NONE);
  assign apply_restart = apply & (cmd_q == wdt_pkg::CMD_RESTART);
  // the lock also stops a disable still waiting in the slot
  assign apply_disable = apply & (cmd_q == wdt_pkg::CMD_DISABLE) & ~lock_q;

  // slow-domain delay
  // one slot suffices as software sends one command per divided period
  always_comb begin
    cmd_d  = cmd_q;
    wait_d = wait_q;
    if (is_restart) begin
      cmd_d  = wdt_pkg::CMD_RESTART;
      wait_d = `WDT_RESTART_TICKS;
    end else if (dis_ok) begin
      cmd_d  = wdt_pkg::CMD_DISABLE;
      wait_d = `WDT_DISABLE_TICKS;
    end else begin
      case (cmd_q)
        wdt_pkg::CMD_NONE: begin
          wait_d = 2'h0;
        end
        wdt_pkg::CMD_RESTART,
        wdt_pkg::CMD_DISABLE: begin
          if (tick) begin
            wait_d = wait_q - 2'h1;
            if (wait_q == 2'h1) begin
              cmd_d = wdt_pkg::CMD_NONE;
            end
          end
        end
        default: begin
          cmd_d  = wdt_pkg::CMD_NONE;
          wait_d = 2'h0;
        end
      endcase
    end
  end

  // enable, lock and interval
  // interval and lock act at once; only restart and disable wait for ticks
  // restart enables
  always_comb begin
    en_d = en_q;
    if (apply_restart) begin
      en_d = 1'b1;
    end else if (apply_disable) begin
      en_d = 1'b0;
    end
  end

  assign lock_d = lock_q | is_lock;

  assign iv_d = is_iv ? wbyte[`WDT_IV_W-1:0] : iv_q;

  // prescaler and counter
  // 32 oscillator rises per tick lets 16 bits reach the longest interval
  // restart clears the prescaler too, so each timeout starts whole
  always_comb begin
    div_d = div_q;
    if (apply_restart) begin
      div_d = '0;
    end else if (lfo_rise) begin
      div_d = div_q + 5'h01;
    end
  end

  always_comb begin
    cnt_d = cnt_q;
    if (apply_restart) begin
      cnt_d = '0;
    end else if (tick & en_q) begin
      cnt_d = cnt_q + 16'h0001;
    end
  end

  // outputs
  // every top-level output below is taken straight from a flip-flop
  // request held until the system reset returns
  // internal request only; the external pin is not driven here
  assign rst_req_d = wdt_rst_req_o | hit;

  // interval readback
  // status word: count, pending command, lock, enable
  always_comb begin
    dat_d = 32'h0000_0000;
    if (ack_d & hit_ctrl) begin
      dat_d = {29'h0000_0000, iv_q};
    end else if (ack_d & hit_stat) begin
      dat_d = {cnt_q, 13'h0000, (cmd_q != wdt_pkg::CMD_NONE), lock_q, en_q};
    end
  end

  // registers; one short block per state so each reset value sits by its use
  // every block resets synchronously, so a reset glitch cannot tear a command
  // reset state
  // enable flag: the watchdog comes up armed after any system reset
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      en_q <= 1'b1;
    end else begin
      en_q <= en_d;
    end
  end

  // lock flag: only a system reset can take it away
  // lock clears on reset
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      lock_q <= 1'b0;
    end else begin
      lock_q <= lock_d;
    end
  end

  // interval field: all ones after reset gives the longest timeout
  // software is trusted to change it only while disabled
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      iv_q <= `WDT_IV_RST;
    end else begin
      iv_q <= iv_d;
    end
  end

  // watchdog count: cleared by reset and by an applied restart only
  // a disable leaves it alone, which is what makes a lowered limit trip
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // prescaler of oscillator rises
  // it runs while disabled too, so tick phase is never lost
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

  // disable window, counted in core clock cycles
  // zero means no first key is outstanding
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      win_q <= 3'h0;
    end else begin
      win_q <= win_d;
    end
  end

  // command slot and its tick countdown
  // reset drops any pending command, as the reset state already holds
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cmd_q  <= wdt_pkg::CMD_NONE;
      wait_q <= 2'h0;
    end else begin
      cmd_q  <= cmd_d;
      wait_q <= wait_d;
    end
  end

  // reset request
  // sticky until the system reset it causes comes back to clear it
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wdt_rst_req_o <= 1'b0;
    end else begin
      wdt_rst_req_o <= rst_req_d;
    end
  end

  // oscillator forced on
  // follows the next enable so it lines up with en_q
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      lfo_force_on_o <= 1'b1;
    end else begin
      lfo_force_on_o <= en_d;
    end
  end

  // bus answer: ack and read data stand for exactly one cycle
  // read data is zero outside ack so a stale value never leaks
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= ack_d;
      wb_dat_o <= dat_d;
    end
  end

endmodule : keyed_watchdog_timer

// ==== verification/keyed_watchdog_timer_assertions.sv ====
// port checks of the keyed watchdog
`include "wdt_defs.svh"
module keyed_watchdog_timer_assertions (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  // wishbone
  input wire logic        wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // watchdog outputs
  input wire logic        lfo_force_on_o,
  input wire logic        wdt_rst_req_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // taken control accesses; shadows clear only at reset, except a5_q, which a disable second key also clears
  wire        ctl = wb_ack_o & (wb_adr_i[11:2] == `WDT_IDX_CTRL);
  wire        cwr = ctl & wb_we_i & wb_sel_i[0];
  wire  [7:0] k   = wb_dat_i[7:0];
  logic [2:0] iv_q;
  logic       lk_q;
  logic       ad_q;
  logic       a5_q;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      iv_q <= `WDT_IV_RST;
      lk_q <= 1'b0;
      ad_q <= 1'b0;
      a5_q <= 1'b0;
    end else if (cwr) begin
      iv_q <= k[7] ? iv_q : k[2:0];
      lk_q <= lk_q | (k == `WDT_KEY_LOCK);
      ad_q <= ad_q | (k == `WDT_KEY_DIS_LAST);
      a5_q <= (k == `WDT_KEY_RESTART) | (a5_q & (k != `WDT_KEY_DIS_LAST));
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  property p_rst;
    $fell(sys_rst_i) |-> lfo_force_on_o && !wdt_rst_req_o && !wb_ack_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_ivrd;
    ctl && !wb_we_i |-> wb_dat_o == {29'h0, iv_q};
  endproperty
  a_ivrd: assert property (p_ivrd) else $error("interval read");
  property p_stick;
    $rose(wdt_rst_req_o) |=> wdt_rst_req_o [*8];
  endproperty
  a_stick: assert property (p_stick) else $error("reset request dropped");
  property p_diskey;
    $fell(lfo_force_on_o) |-> ad_q;
  endproperty
  a_diskey: assert property (p_diskey) else $error("disable without key");
  property p_lkblk;
    $fell(lfo_force_on_o) |-> !lk_q;
  endproperty
  a_lkblk: assert property (p_lkblk) else $error("disable while locked");
  property p_lkkeep;
    cwr && k == `WDT_KEY_LOCK |=> $stable(lfo_force_on_o) [*3];
  endproperty
  a_lkkeep: assert property (p_lkkeep) else $error("lock moved enable");
  property p_ackone;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ackone: assert property (p_ackone) else $error("ack too long");
  property p_enkey;
    $rose(lfo_force_on_o) |-> a5_q;
  endproperty
  a_enkey: assert property (p_enkey) else $error("enable without restart");
  c_lock: cover property (cwr && k == `WDT_KEY_LOCK);
  c_trip: cover property ($rose(wdt_rst_req_o));
  c_dis: cover property ($fell(lfo_force_on_o));
endmodule : keyed_watchdog_timer_assertions

bind keyed_watchdog_timer keyed_watchdog_timer_assertions i_chk (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .lfo_force_on_o(lfo_force_on_o), .wdt_rst_req_o(wdt_rst_req_o)
);

// ==== verification/keyed_watchdog_timer_tb.sv ====
// bench of the keyed watchdog timer
`include "wdt_defs.svh"
module keyed_watchdog_timer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // one divided tick is 32 oscillator rises of 6 clocks
  localparam int          tk = 192;
  localparam logic [11:0] ca = {`WDT_IDX_CTRL, 2'b00};
  localparam logic [11:0] sa = {`WDT_IDX_STAT, 2'b00};
  logic        clk_i, sys_rst_i, cyc, we, ack, lfo, fon, req;
  logic [11:0] adr;
  logic [31:0] wd, rd, q, p;
  int          lc, err_count, n_checks;
  keyed_watchdog_timer i_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wd), .wb_dat_o(rd),
    .wb_ack_o(ack), .low_freq_oscillator_i(lfo), .lfo_force_on_o(fon),
    .wdt_rst_req_o(req)
  );
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // pin held 3 clocks a level, one more than the least the sampler accepts
  always @(posedge clk_i) begin
    lc  <= (lc == 2) ? 0 : lc + 1;
    lfo <= (lc == 2) ? ~lfo : lfo;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict
  // one classic cycle; read data is taken at the ack edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    we  <= w;
    adr <= a;
    wd  <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 9);
    q = rd;
    cyc <= 1'b0;
    @(posedge clk_i);
    if (n == 9) begin
      chk(32'h0, 32'h1);
      give_verdict();
    end
  endtask : bus
  task automatic wc(input logic [7:0] k);
    bus(1'b1, ca, {24'h0, k});
  endtask : wc
  task automatic rs();
    bus(1'b0, sa, 32'h0);
  endtask : rs
  // bounded status poll; commands land only on slow ticks
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do begin
      rs();
      n++;
    end while ((q & m) !== v && n < 500);
    chk(q & m, v);
    if ((q & m) !== v) begin
      give_verdict();
    end
  endtask : poll
  task automatic do_rst();
    sys_rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
  endtask : do_rst
  // reset state, then a second key that comes too late
  task automatic t_late();
    bus(1'b0, ca, 32'h0);
    chk(q, 32'h0000_0007);
    rs();
    chk(q, 32'h0000_0001);
    chk({30'h0, fon, req}, 32'h0000_0002);
    wc(`WDT_KEY_DIS_FIRST);
    repeat (4) @(posedge clk_i);
    wc(`WDT_KEY_DIS_LAST);
    repeat (5 * tk) @(posedge clk_i);
    rs();
    chk({31'h0, q[0]}, 32'h1);
    chk({31'h0, q[31:16] > 16'h0003}, 32'h1);
  endtask : t_late
  // timely disable holds the count; a lowered limit still trips
  task automatic t_disable();
    wc(`WDT_KEY_DIS_FIRST);
    wc(`WDT_KEY_DIS_LAST);
    poll(32'h0000_0005, 32'h0);
    p = q;
    chk({31'h0, fon}, 32'h0);
    repeat (2 * tk) @(posedge clk_i);
    rs();
    chk(q, p);
    wc(8'h03);
    wc(8'h85);
    bus(1'b0, ca, 32'h0);
    chk(q, 32'h0000_0003);
    bus(1'b0, 12'h400, 32'h0);
    chk(q, 32'h0);
    chk({31'h0, req}, 32'h0);
    wc(8'h00);
    repeat (4) @(posedge clk_i);
    chk({31'h0, req}, 32'h1);
  endtask : t_disable
  // lock refuses the disable and leaves the count running
  task automatic t_lock();
    repeat (3 * tk) @(posedge clk_i);
    rs();
    p = q;
    wc(`WDT_KEY_LOCK);
    wc(`WDT_KEY_DIS_FIRST);
    wc(`WDT_KEY_DIS_LAST);
    repeat (5 * tk) @(posedge clk_i);
    rs();
    chk({30'h0, q[1:0]}, 32'h3);
    chk({31'h0, q[31:16] > p[31:16] + 16'h0003}, 32'h1);
    do_rst();
    rs();
    chk({31'h0, q[1]}, 32'h0);
  endtask : t_lock
  // restart first, shorten to interval one, then time out
  task automatic t_timeout();
    int n;
    wc(`WDT_KEY_RESTART);
    repeat (3 * tk) @(posedge clk_i);
    wc(`WDT_KEY_DIS_FIRST);
    wc(`WDT_KEY_DIS_LAST);
    poll(32'h0000_0005, 32'h0);
    wc(8'h01);
    repeat (tk) @(posedge clk_i);
    wc(`WDT_KEY_RESTART);
    repeat (1600) @(posedge clk_i);
    chk({31'h0, req}, 32'h0);
    for (n = 0; n < 600 && req !== 1'b1; n++) begin
      @(posedge clk_i);
    end
    chk({31'h0, req}, 32'h1);
    rs();
    chk({31'h0, q[0]}, 32'h1);
  endtask : t_timeout
  initial begin
    sys_rst_i = 1'b1;
    cyc       = 1'b0;
    we        = 1'b0;
    lfo       = 1'b0;
    adr       = 12'h0;
    wd        = 32'h0;
    lc        = 0;
    err_count = 0;
    n_checks  = 0;
    do_rst();
    t_late();
    t_disable();
    do_rst();
    t_lock();
    t_timeout();
    give_verdict();
  end
endmodule : keyed_watchdog_timer_tb
